// File: bench/headset_plug_and_hook_detect_tb.sv
`timescale 1ns/1ps
module headset_plug_and_hook_detect_tb;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} hpd_row_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, rd_err, plugged = 1'b0, par_press = 1'b0, ser_press = 1'b0;
  logic sense_switch_close, mic_amp_hiz, supply_switch_close, irq_out_n;
  logic plug_switch_n, parallel_button_comparator, second_button_comparator;
  logic saw_hiz, saw_sup, saw_lo, saw_hi;
  int err_count = 0, num_checks = 0, cyc = 0;
  hpd_row_s rows [9] = '{
    '{1'b0, hpd_pkg::OFS_IRQ_STATUS, 32'h0, 32'h0},
    '{1'b0, hpd_pkg::OFS_IRQ_ENABLE, 32'h0, 32'(hpd_pkg::IRQ_ENABLE_RST)},
    '{1'b0, hpd_pkg::OFS_BTN_CTRL1, 32'h0, 32'(hpd_pkg::CTRL1_RST)},
    '{1'b0, hpd_pkg::OFS_BTN_CTRL2, 32'h0, 32'h0},
    '{1'b0, hpd_pkg::OFS_INTERVAL, 32'h0, 32'(hpd_pkg::INTERVAL_RST)},
    '{1'b1, hpd_pkg::OFS_IRQ_STATUS, 32'h7, 32'h0},
    '{1'b1, hpd_pkg::OFS_INTERVAL, 32'h4, 32'h4},
    '{1'b1, hpd_pkg::OFS_SETTLE, 32'h8, 32'h8},
    '{1'b1, hpd_pkg::OFS_DEBOUNCE, 32'h8, 32'h8}};
  always #20 pclk = ~pclk;
  hpd_top #(.RTC_DIV(4), .PLUG_DEB(2)) i_hpd_top (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .plug_switch_n, .parallel_button_comparator,
    .second_button_comparator, .sense_switch_close, .mic_amp_hiz, .supply_switch_close,
    .irq_out_n);
  hpd_jack_model i_hpd_jack_model (.plugged, .par_press, .ser_press, .sense_switch_close,
    .plug_switch_n, .parallel_button_comparator, .second_button_comparator);
  // Timeout and phase watchers
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (mic_amp_hiz === 1'b1) saw_hiz <= 1'b1;
    if (supply_switch_close === 1'b1) saw_sup <= 1'b1;
    if (sense_switch_close === 1'b0) saw_lo <= 1'b1;
    if (sense_switch_close === 1'b1) saw_hi <= 1'b1;
    if (cyc == 30000) begin
      err_count = err_count + 1;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic st(input int n, input logic [31:0] e, input logic q);
    wt(n);
    apb(1'b0, hpd_pkg::OFS_IRQ_STATUS, 32'h0);
    chk("status", rd, e);
    chk("irq_out_n", 32'(irq_out_n), 32'(q));
    apb(1'b1, hpd_pkg::OFS_IRQ_CLEAR, 32'h7);
  endtask
  initial begin
    wt(2);
    chk("reset irq", 32'(irq_out_n), 32'h1);
    presetn <= 1'b1;
    // Register table
    foreach (rows[i]) begin
      if (rows[i].wr) apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk("register", rd, rows[i].e);
    end
    apb(1'b1, 8'h40, 32'h5);
    chk("unmapped err", 32'(rd_err), 32'h1);
    // Plug glitch, insert, masked removal
    plugged <= 1'b1;
    wt(3);
    plugged <= 1'b0;
    st(60, 32'h0, 1'b1);
    plugged <= 1'b1;
    st(40, 32'h1, 1'b0);
    apb(1'b1, hpd_pkg::OFS_IRQ_ENABLE, 32'h5);
    plugged <= 1'b0;
    st(40, 32'h2, 1'b1);
    // Insertion with every source masked, then unmasked
    apb(1'b1, hpd_pkg::OFS_IRQ_ENABLE, 32'h0);
    plugged <= 1'b1;
    wt(40);
    chk("all masked", 32'(irq_out_n), 32'h1);
    apb(1'b1, hpd_pkg::OFS_IRQ_ENABLE, 32'h7);
    st(2, 32'h1, 1'b0);
    // Parallel send press, then a short press
    saw_hiz = 1'b0;
    saw_sup = 1'b0;
    saw_lo = 1'b0;
    par_press <= 1'b1;
    st(300, 32'h4, 1'b0);
    wt(100);
    chk("hiz seen", 32'(saw_hiz), 32'h1);
    chk("supply seen", 32'(saw_sup), 32'h1);
    chk("idle seen", 32'(saw_lo), 32'h1);
    chk("supply open", 32'(supply_switch_close), 32'h0);
    par_press <= 1'b0;
    st(200, 32'h0, 1'b1);
    par_press <= 1'b1;
    wt(10);
    par_press <= 1'b0;
    st(150, 32'h0, 1'b1);
    // Serial only, then both detectors off
    apb(1'b1, hpd_pkg::OFS_BTN_CTRL1, 32'h1);
    ser_press <= 1'b1;
    st(300, 32'h4, 1'b0);
    // Disable in the idle gap so no sense phase is cut short
    wait (sense_switch_close === 1'b1);
    wait (sense_switch_close === 1'b0);
    apb(1'b1, hpd_pkg::OFS_BTN_CTRL2, 32'h1);
    wt(100);
    saw_hi = 1'b0;
    par_press <= 1'b1;
    st(300, 32'h0, 1'b1);
    chk("sense off", 32'(saw_hi), 32'h0);
    ser_press <= 1'b0;
    par_press <= 1'b0;
    apb(1'b1, hpd_pkg::OFS_BTN_CTRL2, 32'h0);
    // Serial release accepted silently before the next press
    st(200, 32'h0, 1'b1);
    // End mode with bias on: continuous, then duty switch
    apb(1'b1, hpd_pkg::OFS_BTN_CTRL1, 32'h16);
    wt(10);
    saw_lo = 1'b0;
    par_press <= 1'b1;
    st(300, 32'h4, 1'b0);
    chk("always on", 32'(saw_lo), 32'h0);
    apb(1'b0, hpd_pkg::OFS_STATE, 32'h0);
    chk("supply kept", 32'(rd[3]), 32'h0);
    par_press <= 1'b0;
    apb(1'b1, hpd_pkg::OFS_BTN_CTRL1, 32'he);
    wt(10);
    saw_lo = 1'b0;
    wt(200);
    chk("duty back", 32'(saw_lo), 32'h1);
    give_verdict();
  end
endmodule
bind hpd_top hpd_chk i_hpd_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .sense_switch_close, .mic_amp_hiz, .supply_switch_close,
  .irq_out_n);

// File: bench/hpd_chk.sv
`timescale 1ns/1ps
module hpd_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sense_switch_close,
  input wire logic mic_amp_hiz,
  input wire logic supply_switch_close,
  input wire logic irq_out_n
);
  // ********************************************************
  // Helper state
  // ********************************************************
  logic acc;
  logic cont_r;
  assign acc = psel && penable;
  // Continuous end mode as last written: end, bias, no duty switch, parallel on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cont_r <= 1'b0;
    end else if (acc && pwrite && paddr == hpd_pkg::OFS_BTN_CTRL1) begin
      cont_r <= pwdata[3:0] == 4'h6;
    end
  end
  // ********************************************************
  // Properties
  // ********************************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_high_a: assert property (pready) else $error("pready low");
  unmapped_err_a: assert property (acc && paddr > 8'h20 |-> pslverr)
    else $error("no error on unmapped access");
  unmapped_zero_a: assert property (acc && !pwrite && paddr > 8'h20 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  hiz_active_a: assert property (mic_amp_hiz |-> sense_switch_close)
    else $error("amplifier high-z outside detection");
  supply_active_a: assert property (supply_switch_close |-> sense_switch_close)
    else $error("supply switch closed while idle");
  sense_width_a: assert property ($rose(sense_switch_close) |=> sense_switch_close[*3])
    else $error("sense phase too short");
  cont_sense_a: assert property (cont_r[*4] |-> sense_switch_close)
    else $error("continuous mode not sensing");
  mask_all_a: assert property (acc && pwrite && paddr == hpd_pkg::OFS_IRQ_ENABLE &&
    pwdata[2:0] == 3'h0 |-> ##2 irq_out_n)
    else $error("interrupt low with all sources masked");
endmodule

// File: bench/hpd_jack_model.sv
`timescale 1ns/1ps
module hpd_jack_model (
  input wire logic plugged,
  input wire logic par_press,
  input wire logic ser_press,
  input wire logic sense_switch_close,
  output logic plug_switch_n,
  output logic parallel_button_comparator,
  output logic second_button_comparator
);
  // Switch to ground when inserted, pull-up high otherwise
  assign plug_switch_n = ~plugged;
  // Comparators only see the button while the sense switch feeds the mic
  assign parallel_button_comparator = sense_switch_close & par_press;
  assign second_button_comparator = sense_switch_close & ser_press;
endmodule

// File: rtl/hpd_pkg.sv
package hpd_pkg;
  // ********************************************************
  // Timing
  // ********************************************************
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned RTC_HZ = 32768;
  localparam int unsigned RTC_DIV = CLK_HZ / RTC_HZ;
  localparam int unsigned PLUG_DEB_TICKS = 8;
  localparam int unsigned SYNC_STAGES = 3;

  // ********************************************************
  // Register offsets
  // ********************************************************
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h00;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h04;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h08;
  localparam logic [7:0] OFS_BTN_CTRL1 = 8'h0c;
  localparam logic [7:0] OFS_BTN_CTRL2 = 8'h10;
  localparam logic [7:0] OFS_INTERVAL = 8'h14;
  localparam logic [7:0] OFS_SETTLE = 8'h18;
  localparam logic [7:0] OFS_DEBOUNCE = 8'h1c;
  localparam logic [7:0] OFS_STATE = 8'h20;

  // ********************************************************
  // Fields and reset values
  // ********************************************************
  localparam int unsigned IRQ_PLUG = 0;
  localparam int unsigned IRQ_UNPLUG = 1;
  localparam int unsigned IRQ_BUTTON = 2;
  localparam int unsigned IRQ_W = 3;
  localparam logic [2:0] IRQ_ENABLE_RST = 3'h7;
  localparam logic [15:0] INTERVAL_RST = 16'hcccc;
  localparam logic [7:0] SETTLE_RST = 8'h08;
  localparam logic [7:0] DEBOUNCE_RST = 8'h08;

  // Control word one, high bits downward
  typedef struct packed {
    logic supply_rearm;
    logic duty_cycle_switch_enable;
    logic mic_bias_enable;
    logic end_mode;
    logic parallel_detect_disable;
  } hpd_ctrl1_s;
  localparam int unsigned CTRL1_W = 5;
  localparam logic [4:0] CTRL1_RST = 5'h00;

  // Hook sequencer phases
  typedef enum logic [1:0] {
    HPD_IDLE,
    HPD_SETTLE,
    HPD_COMPARE
  } hpd_phase_e;
endpackage

// File: rtl/hpd_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Plug comparator debounced before any event
// - Debounced plug change raises plug or unplug interrupt
// - Both detectors run; separate disable bits
// - Bias amplifier high-Z during parallel send detection
// - Interval, settle, debounce counted in RTC ticks
// - Sense switch closed only settle and compare
// - End mode with bias on: continuous detection
// - Duty switch enable restores duty cycling
// - Serial and parallel outputs combined before debounce
// - Send event: interrupt, open supply switch
// - End event: interrupt only, switch untouched
// - Active-low interrupt while unmasked event pending
// - Each interrupt source has own mask
// - Insert, remove, button are distinct events
module hpd_top #(
  parameter int unsigned RTC_DIV = hpd_pkg::RTC_DIV,
  parameter int unsigned PLUG_DEB = hpd_pkg::PLUG_DEB_TICKS,
  parameter int unsigned INT_W = 16,
  parameter int unsigned PH_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic plug_switch_n,
  input wire logic parallel_button_comparator,
  input wire logic second_button_comparator,
  output logic sense_switch_close,
  output logic mic_amp_hiz,
  output logic supply_switch_close,
  output logic irq_out_n
);

  // ********************************************************
  // Helpers
  // ********************************************************
  // Level from a three-stage synchroniser: moves when the last two agree
  function automatic logic sync_level(input logic [2:0] s, input logic prev);
    sync_level = (s[1] == s[2]) ? s[2] : prev;
  endfunction

  // ********************************************************
  // Registers
  // ********************************************************
  logic [hpd_pkg::IRQ_W-1:0] status_r;
  logic [hpd_pkg::IRQ_W-1:0] enable_r;
  hpd_pkg::hpd_ctrl1_s ctrl1_r;
  logic serial_detect_disable_r;
  logic [INT_W-1:0] interval_r;
  logic [PH_W-1:0] settle_r;
  logic [PH_W-1:0] debounce_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [hpd_pkg::IRQ_W-1:0] irq_set;
  logic [hpd_pkg::IRQ_W-1:0] irq_clr;
  logic wr_en;
  logic setup;
  logic mapped;
  logic supply_open_r;
  logic [2:0] plug_sync_r;
  logic [2:0] par_sync_r;
  logic [2:0] ser_sync_r;
  logic plug_lvl_r;
  logic par_lvl_r;
  logic ser_lvl_r;
  logic plugged_r;
  logic [7:0] plug_cnt_r;
  logic [15:0] div_r;
  logic tick;
  hpd_pkg::hpd_phase_e phase_r;
  logic [INT_W-1:0] phase_cnt_r;
  logic [PH_W-1:0] deb_cnt_r;
  logic pressed_r;
  logic continuous;
  logic any_enabled;
  logic combined;
  logic send_event;

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  // Address decode
  always_comb begin
    unique case (paddr)
      hpd_pkg::OFS_IRQ_STATUS, hpd_pkg::OFS_IRQ_CLEAR, hpd_pkg::OFS_IRQ_ENABLE,
      hpd_pkg::OFS_BTN_CTRL1, hpd_pkg::OFS_BTN_CTRL2, hpd_pkg::OFS_INTERVAL,
      hpd_pkg::OFS_SETTLE, hpd_pkg::OFS_DEBOUNCE, hpd_pkg::OFS_STATE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      pslverr_r <= ~mapped;
      prdata_r <= 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          hpd_pkg::OFS_IRQ_STATUS: prdata_r <= 32'(status_r);
          hpd_pkg::OFS_IRQ_ENABLE: prdata_r <= 32'(enable_r);
          hpd_pkg::OFS_BTN_CTRL1: prdata_r <= 32'(ctrl1_r);
          hpd_pkg::OFS_BTN_CTRL2: prdata_r <= 32'(serial_detect_disable_r);
          hpd_pkg::OFS_INTERVAL: prdata_r <= 32'(interval_r);
          hpd_pkg::OFS_SETTLE: prdata_r <= 32'(settle_r);
          hpd_pkg::OFS_DEBOUNCE: prdata_r <= 32'(debounce_r);
          hpd_pkg::OFS_STATE: prdata_r <= {26'h0, phase_r, supply_open_r,
            sense_switch_close, pressed_r, plugged_r};
          default: prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r <= hpd_pkg::IRQ_ENABLE_RST;
      ctrl1_r <= hpd_pkg::CTRL1_RST;
      serial_detect_disable_r <= 1'b0;
      interval_r <= INT_W'(hpd_pkg::INTERVAL_RST);
      settle_r <= PH_W'(hpd_pkg::SETTLE_RST);
      debounce_r <= PH_W'(hpd_pkg::DEBOUNCE_RST);
    end else if (wr_en) begin
      unique case (paddr)
        hpd_pkg::OFS_IRQ_ENABLE: enable_r <= pwdata[hpd_pkg::IRQ_W-1:0];
        hpd_pkg::OFS_BTN_CTRL1: ctrl1_r <= pwdata[hpd_pkg::CTRL1_W-1:0];
        hpd_pkg::OFS_BTN_CTRL2: serial_detect_disable_r <= pwdata[0];
        hpd_pkg::OFS_INTERVAL: interval_r <= pwdata[INT_W-1:0];
        hpd_pkg::OFS_SETTLE: settle_r <= pwdata[PH_W-1:0];
        hpd_pkg::OFS_DEBOUNCE: debounce_r <= pwdata[PH_W-1:0];
        default: ;
      endcase
    end
  end

  // ********************************************************
  // Interrupts
  // ********************************************************
  // Write-one-to-clear; a set in the same cycle wins
  assign irq_clr = (wr_en && paddr == hpd_pkg::OFS_IRQ_CLEAR) ?
    pwdata[hpd_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~irq_clr) | irq_set;
    end
  end

  // Active-low level output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= ~|(((status_r & ~irq_clr) | irq_set) & enable_r);
    end
  end

  // ********************************************************
  // Input synchronisers and RTC tick
  // ********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      plug_sync_r <= 3'h7;
      par_sync_r <= 3'h0;
      ser_sync_r <= 3'h0;
      plug_lvl_r <= 1'b1;
      par_lvl_r <= 1'b0;
      ser_lvl_r <= 1'b0;
    end else begin
      plug_sync_r <= {plug_sync_r[1:0], plug_switch_n};
      par_sync_r <= {par_sync_r[1:0], parallel_button_comparator};
      ser_sync_r <= {ser_sync_r[1:0], second_button_comparator};
      plug_lvl_r <= sync_level(plug_sync_r, plug_lvl_r);
      par_lvl_r <= sync_level(par_sync_r, par_lvl_r);
      ser_lvl_r <= sync_level(ser_sync_r, ser_lvl_r);
    end
  end

  // Divider standing in for the RTC clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= tick ? 16'h0000 : div_r + 16'h0001;
    end
  end
  assign tick = (div_r == 16'(RTC_DIV - 1));

  // ********************************************************
  // Plug detection
  // ********************************************************
  // Switch low means inserted; change accepted after PLUG_DEB stable ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      plugged_r <= 1'b0;
      plug_cnt_r <= 8'h00;
    end else if (~plug_lvl_r == plugged_r) begin
      plug_cnt_r <= 8'h00;
    end else if (tick) begin
      if (plug_cnt_r == 8'(PLUG_DEB - 1)) begin
        plugged_r <= ~plug_lvl_r;
        plug_cnt_r <= 8'h00;
      end else begin
        plug_cnt_r <= plug_cnt_r + 8'h01;
      end
    end
  end

  // ********************************************************
  // Hook sequencer
  // ********************************************************
  assign any_enabled = ~ctrl1_r.parallel_detect_disable | ~serial_detect_disable_r;
  assign continuous = ctrl1_r.end_mode & ctrl1_r.mic_bias_enable &
    ~ctrl1_r.duty_cycle_switch_enable;
  assign combined = (par_lvl_r & ~ctrl1_r.parallel_detect_disable) |
    (ser_lvl_r & ~serial_detect_disable_r);

  // Interval, settle and compare phases in RTC ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= hpd_pkg::HPD_IDLE;
      phase_cnt_r <= '0;
    end else if (!any_enabled) begin
      phase_r <= hpd_pkg::HPD_IDLE;
      phase_cnt_r <= '0;
    end else if (continuous) begin
      phase_r <= hpd_pkg::HPD_COMPARE;
      phase_cnt_r <= '0;
    end else if (tick) begin
      phase_cnt_r <= phase_cnt_r + 1'b1;
      unique case (phase_r)
        hpd_pkg::HPD_IDLE: if (phase_cnt_r >= interval_r - 1'b1) begin
          phase_r <= hpd_pkg::HPD_SETTLE;
          phase_cnt_r <= '0;
        end
        hpd_pkg::HPD_SETTLE: if (phase_cnt_r >= INT_W'(settle_r) - 1'b1) begin
          phase_r <= hpd_pkg::HPD_COMPARE;
          phase_cnt_r <= '0;
        end
        hpd_pkg::HPD_COMPARE: if (phase_cnt_r >= INT_W'(debounce_r) - 1'b1) begin
          phase_r <= hpd_pkg::HPD_IDLE;
          phase_cnt_r <= '0;
        end
      endcase
    end
  end

  // Comparator debounce during compare phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pressed_r <= 1'b0;
      deb_cnt_r <= '0;
    end else if (phase_r != hpd_pkg::HPD_COMPARE || combined == pressed_r) begin
      deb_cnt_r <= '0;
    end else if (tick) begin
      if (deb_cnt_r >= debounce_r - 1'b1) begin
        pressed_r <= combined;
        deb_cnt_r <= '0;
      end else begin
        deb_cnt_r <= deb_cnt_r + 1'b1;
      end
    end
  end

  // Accepted press is the hook event
  assign send_event = tick && phase_r == hpd_pkg::HPD_COMPARE && combined && !pressed_r &&
    deb_cnt_r >= debounce_r - 1'b1;

  // Event sources into the status bits
  always_comb begin
    irq_set = '0;
    irq_set[hpd_pkg::IRQ_PLUG] = tick && ~plug_lvl_r && !plugged_r &&
      plug_cnt_r == 8'(PLUG_DEB - 1);
    irq_set[hpd_pkg::IRQ_UNPLUG] = tick && plug_lvl_r && plugged_r &&
      plug_cnt_r == 8'(PLUG_DEB - 1);
    irq_set[hpd_pkg::IRQ_BUTTON] = send_event;
  end

  // Supply switch opened on a send event, rearmed by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_open_r <= 1'b0;
    end else if (send_event && !ctrl1_r.end_mode) begin
      supply_open_r <= 1'b1;
    end else if (wr_en && paddr == hpd_pkg::OFS_BTN_CTRL1 && pwdata[4]) begin
      supply_open_r <= 1'b0;
    end
  end

  // ********************************************************
  // Analog controls
  // ********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_switch_close <= 1'b0;
      mic_amp_hiz <= 1'b0;
      supply_switch_close <= 1'b0;
    end else begin
      sense_switch_close <= phase_r != hpd_pkg::HPD_IDLE;
      mic_amp_hiz <= phase_r != hpd_pkg::HPD_IDLE && !ctrl1_r.end_mode &&
        !ctrl1_r.parallel_detect_disable;
      supply_switch_close <= phase_r != hpd_pkg::HPD_IDLE && !ctrl1_r.end_mode &&
        !supply_open_r;
    end
  end

endmodule
